// [logic/pin_sync.v]
// Two-flop synchroniser for the port C pin levels.
// Assumes pins are asynchronous to clk_i.
`timescale 1ns/1ps
`include "port_c_mux_consts.vh"
module pin_sync #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire rst_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);
    // First stage, read only by second stage
    reg [WIDTH-1:0] meta;

    // Two flip-flop chain
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta <= {WIDTH{1'b0}};
            sync_o <= {WIDTH{1'b0}};
        end else begin
            meta <= async_i;
            sync_o <= meta;
        end
    end
endmodule // pin_sync

// [logic/port_c_alt_function_mux.v]
// Alternate-function override for the eight port C pins.
// Assumes port registers and peripheral controls share clk_i.
// Contract
// - Bit1 carries timer1 compare B in PWM
// - SPI slave forces alternate select to input
// - SPI master: select direction follows port D
// - Forced input keeps pull-up from port D
// - Bit0 feeds external interrupt source 3
// - Bit3 is timer1 alternate capture input
// - Bit3 counts timer1, bit2 counts timer0
// - Pins 7..0 feed pin-change lines 15..8
`timescale 1ns/1ps
`include "port_c_mux_consts.vh"
module port_c_alt_function_mux #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire rst_i,
    // Ordinary port C registers
    input wire [WIDTH-1:0] port_c_direction_i,
    input wire [WIDTH-1:0] port_c_output_value_i,
    input wire pull_up_disable_i,
    // Port D bit 0 registers steering alternate select
    input wire port_d_bit0_direction_i,
    input wire port_d_bit0_output_value_i,
    // Peripheral controls
    input wire timer1_compare_b_enable_i,
    input wire timer1_compare_b_out_i,
    input wire spi_enable_i,
    input wire spi_master_i,
    input wire spi_alt_pins_i,
    input wire can_transmit_enable_i,
    input wire can_transmit_out_i,
    input wire dac_enable_i,
    input wire psc1_out_enable_i,
    input wire psc1_out_i,
    input wire irq3_enable_i,
    // Raw pin levels
    input wire [WIDTH-1:0] pin_level_i,
    // Pin drive
    output reg [WIDTH-1:0] pin_out_o,
    output reg [WIDTH-1:0] pin_oe_o,
    output reg [WIDTH-1:0] pin_pull_up_o,
    // Alternate select pin drive (on port D bit 0 side)
    output reg ss_alt_oe_o,
    output reg ss_alt_pull_up_o,
    // Peripheral inputs
    output reg external_irq_source3_o,
    output reg timer1_capture_alt_in_o,
    output reg timer1_external_count_in_o,
    output reg timer0_external_count_in_o,
    output reg can_receive_in_o,
    output reg spi_slave_select_o,
    output reg psc1_digital_in_o,
    output reg [15:8] pin_change_line_o,
    output reg [WIDTH-1:0] pin_read_o
);
    // Synchronised pin levels, two flops behind the pads
    wire [WIDTH-1:0] pin_synced;
    // Pull-up each pin would get from the port registers alone
    wire [WIDTH-1:0] plain_pu;
    // Next pin value after overrides
    reg [WIDTH-1:0] next_out;
    // Next pin driver enable after overrides
    reg [WIDTH-1:0] next_oe;
    // Next pin pull-up after overrides
    reg [WIDTH-1:0] next_pu;
    // Next driver enable of the alternate select pin
    reg next_ss_oe;
    // Next pull-up of the alternate select pin
    reg next_ss_pu;
    // SPI slave using the alternate select pin
    wire spi_alt_slave;
    // Loop index for the per-pin pull-up
    genvar gi;

    // Pull-up of a plain port pin: input, value high, not globally off
    function pull_up_of;
        // Direction bit, high drives the pin
        input dir;
        // Output value bit, doubles as pull-up request
        input val;
        // Global pull-up disable
        input pud;
        begin
            pull_up_of = ~dir & val & ~pud;
        end
    endfunction

    // Slave role on the alternate select pin
    assign spi_alt_slave = spi_enable_i & ~spi_master_i & spi_alt_pins_i;

    // Pin synchroniser, pads are asynchronous to clk_i
    pin_sync #(
        .WIDTH(WIDTH)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i(pin_level_i),
        .sync_o(pin_synced)
    );

    generate
        for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_plain_pu
            // Same rule on every pin
            assign plain_pu[gi] = pull_up_of(port_c_direction_i[gi], port_c_output_value_i[gi], pull_up_disable_i);
        end
    endgenerate

    // Combinational override of port defaults
    always @* begin
        next_out = port_c_output_value_i;
        next_oe = port_c_direction_i;
        next_pu = plain_pu;
        if (timer1_compare_b_enable_i) begin
            // Value only, direction stays with software
            next_out[`PC_BIT_CMPB] = timer1_compare_b_out_i;
        end
        // PSC output on bit 0 takes the pin
        if (psc1_out_enable_i) begin
            // Driven output, pull-up off
            next_out[`PC_BIT_IRQ3] = psc1_out_i;
            next_oe[`PC_BIT_IRQ3] = 1'b1;
            next_pu[`PC_BIT_IRQ3] = 1'b0;
        end
        // CAN transmit on bit 2 takes the pin
        if (can_transmit_enable_i) begin
            // Driven output, pull-up off
            next_out[`PC_BIT_CNT0] = can_transmit_out_i;
            next_oe[`PC_BIT_CNT0] = 1'b1;
            next_pu[`PC_BIT_CNT0] = 1'b0;
        end
        // DAC output: digital driver released
        if (dac_enable_i) begin
            next_oe[`PC_BIT_ANALOG] = 1'b0;
            next_pu[`PC_BIT_ANALOG] = 1'b0;
        end
    end

    // Alternate select direction and pull-up
    always @* begin
        if (spi_alt_slave) begin
            next_ss_oe = 1'b0;
            // pull-up still from port D value
            next_ss_pu = port_d_bit0_output_value_i & ~pull_up_disable_i;
        end else begin
            // master or idle, port D direction
            next_ss_oe = port_d_bit0_direction_i;
            // Plain port rule for the pull-up
            next_ss_pu = pull_up_of(port_d_bit0_direction_i, port_d_bit0_output_value_i, pull_up_disable_i);
        end
    end

    // Registered pin drive
    always @(posedge clk_i) begin
        if (rst_i) begin
            // All pins input, no pull-up
            pin_out_o <= {WIDTH{`PC_RESET_BIT}};
            pin_oe_o <= {WIDTH{`PC_RESET_BIT}};
            pin_pull_up_o <= {WIDTH{`PC_RESET_BIT}};
        end else begin
            // Overrides applied
            pin_out_o <= next_out;
            pin_oe_o <= next_oe;
            pin_pull_up_o <= next_pu;
        end
    end

    // Registered alternate select drive
    always @(posedge clk_i) begin
        if (rst_i) begin
            // Select pin released
            ss_alt_oe_o <= `PC_RESET_BIT;
            ss_alt_pull_up_o <= `PC_RESET_BIT;
        end else begin
            // slave forces input; master follows port D
            ss_alt_oe_o <= next_ss_oe;
            ss_alt_pull_up_o <= next_ss_pu;
        end
    end

    // Registered peripheral inputs from the synchronised pins
    always @(posedge clk_i) begin
        if (rst_i) begin
            // Peripherals see idle low inputs
            external_irq_source3_o <= `PC_RESET_BIT;
            timer1_capture_alt_in_o <= `PC_RESET_BIT;
            timer1_external_count_in_o <= `PC_RESET_BIT;
            timer0_external_count_in_o <= `PC_RESET_BIT;
            can_receive_in_o <= `PC_RESET_BIT;
            spi_slave_select_o <= `PC_RESET_BIT;
            psc1_digital_in_o <= `PC_RESET_BIT;
        end else begin
            // interrupt source 3, gated by its enable
            external_irq_source3_o <= irq3_enable_i & pin_synced[`PC_BIT_IRQ3];
            timer1_capture_alt_in_o <= pin_synced[`PC_BIT_CNT1];
            timer1_external_count_in_o <= pin_synced[`PC_BIT_CNT1];
            timer0_external_count_in_o <= pin_synced[`PC_BIT_CNT0];
            // CAN receive shares bit 3
            can_receive_in_o <= pin_synced[`PC_BIT_CNT1];
            // active-low select, deasserted when not slave
            spi_slave_select_o <= spi_alt_slave & ~pin_synced[`PC_BIT_CMPB];
            // PSC digital input shares bit 1
            psc1_digital_in_o <= pin_synced[`PC_BIT_CMPB];
        end
    end

    // Registered pin-change lines and port read-back
    always @(posedge clk_i) begin
        if (rst_i) begin
            // No change seen during reset
            pin_change_line_o <= {WIDTH{`PC_RESET_BIT}};
            pin_read_o <= {WIDTH{`PC_RESET_BIT}};
        end else begin
            pin_change_line_o <= pin_synced;
            // Read-back of the pad levels
            pin_read_o <= pin_synced;
        end
    end
endmodule // port_c_alt_function_mux

// [logic/port_c_mux_consts.vh]
// Constants for the port C alternate-function mux.
// Assumes inclusion by bare name from logic/ files.
`ifndef PORT_C_MUX_CONSTS_VH
`define PORT_C_MUX_CONSTS_VH
// Port width
`define PC_WIDTH 8
// Pin positions of alternate functions
`define PC_BIT_IRQ3 0
`define PC_BIT_CMPB 1
`define PC_BIT_CNT0 2
`define PC_BIT_CNT1 3
`define PC_BIT_ANALOG 7
// First pin-change line fed by port C
`define PC_CHANGE_LINE_BASE 8
// Reset values
`define PC_RESET_BYTE 8'h00
`define PC_RESET_BIT 1'b0
`endif

// [sim/board_model.sv]
// Board side of port C: external parts driving the pin levels.
// Assumes levels change only at the system clock edge.
`timescale 1ns/1ps
module board_model (
    input wire clk_i,
    input wire [7:0] drive_i,
    output logic [7:0] pin_o
);
    always_ff @(posedge clk_i) pin_o <= drive_i;
endmodule // board_model

// [sim/port_c_mux_checker.sv]
// Checker for the port C mux, bound to its ports.
// Assumes one clock and a synchronous reset.
`timescale 1ns/1ps
module port_c_checker (
    input wire clk_i, rst_i, pull_up_disable_i, port_d_bit0_direction_i, port_d_bit0_output_value_i,
    input wire timer1_compare_b_enable_i, timer1_compare_b_out_i, spi_enable_i, spi_master_i, spi_alt_pins_i,
    input wire ss_alt_oe_o, ss_alt_pull_up_o, timer0_external_count_in_o, spi_slave_select_o,
    input wire [7:0] port_c_direction_i, pin_level_i, pin_out_o, pin_oe_o,
    input wire [15:8] pin_change_line_o
);
    logic [1:0] up; // Edges since reset, stops at 3
    always_ff @(posedge clk_i) up <= rst_i ? 2'h0 : up + {1'b0, ~&up};
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    wire sl = spi_enable_i & spi_alt_pins_i & ~spi_master_i; // Slave on alternate select
    wire sm = spi_enable_i & spi_alt_pins_i & spi_master_i; // Master on alternate select
    property p_cmp; timer1_compare_b_enable_i |=> pin_out_o[1] == $past(timer1_compare_b_out_i); endproperty
    a_cmp: assert property (p_cmp) else $error("compare pin");
    property p_slv; sl |=> !ss_alt_oe_o; endproperty
    a_slv: assert property (p_slv) else $error("select driven");
    property p_mst; sm |=> ss_alt_oe_o == $past(port_d_bit0_direction_i); endproperty
    a_mst: assert property (p_mst) else $error("select direction");
    property p_pu; sl |=> ss_alt_pull_up_o == $past(port_d_bit0_output_value_i & ~pull_up_disable_i); endproperty
    a_pu: assert property (p_pu) else $error("select pull-up");
    property p_sel; &up |-> spi_slave_select_o == ($past(sl) && !$past(pin_level_i[1], 3)); endproperty
    a_sel: assert property (p_sel) else $error("slave select");
    property p_pcl; &up |-> pin_change_line_o == $past(pin_level_i, 3); endproperty
    a_pcl: assert property (p_pcl) else $error("pin change");
    property p_cnt; &up |-> timer0_external_count_in_o == $past(pin_level_i[2], 3); endproperty
    a_cnt: assert property (p_cnt) else $error("timer0 count");
    property p_own; 1 |=> pin_oe_o[6:4] == $past(port_c_direction_i[6:4]); endproperty
    a_own: assert property (p_own) else $error("plain direction");
    c_slv: cover property (&up && spi_slave_select_o);
    c_cmp: cover property (timer1_compare_b_enable_i);
    c_mst: cover property (sm);
endmodule // port_c_checker
bind port_c_alt_function_mux port_c_checker chk (.*);

// [sim/testbench.sv]
// Bench for the port C mux: control steps and board pin patterns.
// Assumes the board model and the bound checker are compiled first.
`timescale 1ns/1ps
module testbench;
    logic clk_i = 0, rst_i = 1, pull_up_disable_i = 0, port_d_bit0_direction_i = 1, port_d_bit0_output_value_i = 1;
    logic timer1_compare_b_enable_i = 0, timer1_compare_b_out_i = 0, spi_enable_i = 0, spi_master_i = 0;
    logic spi_alt_pins_i = 1, irq3_enable_i = 1, can_transmit_enable_i = 0, can_transmit_out_i = 0;
    logic dac_enable_i = 0, psc1_out_enable_i = 0, psc1_out_i = 0, ss_alt_oe_o, ss_alt_pull_up_o;
    logic external_irq_source3_o, timer1_capture_alt_in_o, timer1_external_count_in_o, timer0_external_count_in_o;
    logic can_receive_in_o, spi_slave_select_o, psc1_digital_in_o;
    logic [7:0] port_c_direction_i = 8'hA5, port_c_output_value_i = 8'h3C, drv = 8'hFF;
    logic [7:0] pin_level_i, pin_out_o, pin_oe_o, pin_pull_up_o, pin_read_o;
    logic [15:8] pin_change_line_o;
    int n_mismatch = 0, checks = 0;
    always #12.5 clk_i = ~clk_i;
    port_c_alt_function_mux dut (.*);
    board_model board (.clk_i(clk_i), .drive_i(drv), .pin_o(pin_level_i));
    task step(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    task chk(input string s, input logic [7:0] e, g);
        checks++;
        if (g !== e) n_mismatch++;
        if (g !== e) $display("[ERR] %s expected %h seen %h", s, e, g);
    endtask
    task complete_run;
        $display("checks %0d n_mismatch %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        complete_run;
    end
    initial begin
        step(4);
        rst_i = 0;
        step(2);
        chk("plain", 8'h30, pin_out_o & 8'h70);
        port_c_direction_i = 8'hA7;
        timer1_compare_b_enable_i = 1;
        timer1_compare_b_out_i = 1;
        step(1);
        chk("cmpb", 8'h02, pin_out_o & 8'h02);
        chk("cmpb_dir", 8'h02, pin_oe_o & 8'h02);
        chk("pull_up", 8'h18, pin_pull_up_o);
        spi_enable_i = 1;
        drv = 8'hFD;
        step(5);
        chk("select", 8'h01, {7'h0, spi_slave_select_o});
        chk("select_oe", 8'h00, {7'h0, ss_alt_oe_o});
        chk("select_pu", 8'h01, {7'h0, ss_alt_pull_up_o});
        spi_master_i = 1;
        pull_up_disable_i = 1;
        drv = 8'h39;
        step(5);
        chk("irq3", 8'h01, {7'h0, external_irq_source3_o});
        chk("timer1_inputs", 8'h03, {6'h0, timer1_capture_alt_in_o, timer1_external_count_in_o});
        chk("other_inputs", 8'h04, {5'h0, can_receive_in_o, psc1_digital_in_o, timer0_external_count_in_o});
        chk("pin_change", 8'h39, pin_change_line_o);
        chk("select_dir", 8'h01, {7'h0, ss_alt_oe_o});
        chk("select_idle", 8'h00, {7'h0, spi_slave_select_o});
        // Overrides on bits 0, 2 and 7
        pull_up_disable_i = 0;
        port_c_direction_i = 8'hA2;
        port_c_output_value_i = 8'hBD;
        psc1_out_enable_i = 1;
        psc1_out_i = 1;
        can_transmit_enable_i = 1;
        dac_enable_i = 1;
        step(1);
        chk("alt_out", 8'hBB, pin_out_o);
        chk("alt_oe", 8'h27, pin_oe_o);
        chk("alt_pu", 8'h18, pin_pull_up_o);
        port_c_direction_i = 8'h22;
        port_c_output_value_i = 8'h3D;
        dac_enable_i = 0;
        step(1);
        chk("amp_pin", 8'h00, (pin_oe_o | pin_pull_up_o) & 8'h80);
        // Mid-run reset clears every output
        rst_i = 1;
        step(1);
        chk("reset", 8'h00, pin_out_o | pin_oe_o | pin_pull_up_o | pin_read_o);
        rst_i = 0;
        step(4);
        chk("pin_read", 8'h39, pin_read_o);
        complete_run;
    end
endmodule // testbench
